// ---- sbst_dev.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "sbst_map.svh"
// Overview of operation
// - Instruction, bypass, identification, boundary chains shift serially.
// - Identification bits 31:29 hold version.
// - Identification bits 28:12 hold part code.
// - Identification bits 11:1 hold maker code.
// - Identification bit 0 always one.
// - Code 000 selects external test.
// - Code 001 selects identification, memory unaffected.
// - Code 010 samples, forces outputs high impedance.
// - Code 100 samples without disturbing memory.
// - Controller loads reserved codes, which select the bypass bit.
// - Code 111 selects the one-bit bypass.
// - Host holds PLL disable defined at power-up.
// - Host raises PLL disable, waits 20 us.
// - PLL reference is the main clock.
// - PLL works down to 120 MHz.
// - Host gives 20 us stable clock to relock.
// - Cell 108 enables read outputs under external test.
// - Identification selected at reset and test-logic-reset.
// - High impedance forcing holds until next update.
module sbst_dev #(
   parameter logic [2:0]  ID_VER   = 3'h5,       // Arbitrary value.
   parameter logic [16:0] ID_PART  = 17'h0_a5c5, // Arbitrary value.
   parameter logic [10:0] ID_MAKER = 11'h25b     // Arbitrary value.
) (
   input  wire logic                     mclk,
   input  wire logic                     rst_b,
   sbst_if.dev                           lnk,
   input  wire logic [`SBST_BSR_W-2:0]   ring_in,
   output logic      [`SBST_BSR_W-2:0]   bsr_drive,
   output logic                          extest_on,
   output logic                          q_hiz,
   output logic                          pll_locked
);
   // ****************************************************************
   // Next-state function of the test access controller
   // ****************************************************************
   function automatic sbst_pkg::sbst_tap_t next_st(
      input sbst_pkg::sbst_tap_t st,
      input logic                tms
   );
      case (st)
         sbst_pkg::sbst_tlr:    next_st = tms ? sbst_pkg::sbst_tlr    : sbst_pkg::sbst_rti;
         sbst_pkg::sbst_rti:    next_st = tms ? sbst_pkg::sbst_sel_dr : sbst_pkg::sbst_rti;
         sbst_pkg::sbst_sel_dr: next_st = tms ? sbst_pkg::sbst_sel_ir : sbst_pkg::sbst_cap_dr;
         sbst_pkg::sbst_cap_dr: next_st = tms ? sbst_pkg::sbst_ex1_dr : sbst_pkg::sbst_shf_dr;
         sbst_pkg::sbst_shf_dr: next_st = tms ? sbst_pkg::sbst_ex1_dr : sbst_pkg::sbst_shf_dr;
         sbst_pkg::sbst_ex1_dr: next_st = tms ? sbst_pkg::sbst_upd_dr : sbst_pkg::sbst_pau_dr;
         sbst_pkg::sbst_pau_dr: next_st = tms ? sbst_pkg::sbst_ex2_dr : sbst_pkg::sbst_pau_dr;
         sbst_pkg::sbst_ex2_dr: next_st = tms ? sbst_pkg::sbst_upd_dr : sbst_pkg::sbst_shf_dr;
         sbst_pkg::sbst_upd_dr: next_st = tms ? sbst_pkg::sbst_sel_dr : sbst_pkg::sbst_rti;
         sbst_pkg::sbst_sel_ir: next_st = tms ? sbst_pkg::sbst_tlr    : sbst_pkg::sbst_cap_ir;
         sbst_pkg::sbst_cap_ir: next_st = tms ? sbst_pkg::sbst_ex1_ir : sbst_pkg::sbst_shf_ir;
         sbst_pkg::sbst_shf_ir: next_st = tms ? sbst_pkg::sbst_ex1_ir : sbst_pkg::sbst_shf_ir;
         sbst_pkg::sbst_ex1_ir: next_st = tms ? sbst_pkg::sbst_upd_ir : sbst_pkg::sbst_pau_ir;
         sbst_pkg::sbst_pau_ir: next_st = tms ? sbst_pkg::sbst_ex2_ir : sbst_pkg::sbst_pau_ir;
         sbst_pkg::sbst_ex2_ir: next_st = tms ? sbst_pkg::sbst_upd_ir : sbst_pkg::sbst_shf_ir;
         sbst_pkg::sbst_upd_ir: next_st = tms ? sbst_pkg::sbst_sel_dr : sbst_pkg::sbst_rti;
         default:               next_st = sbst_pkg::sbst_tlr;
      endcase
   endfunction : next_st

   // ****************************************************************
   // Pin synchronisers and test clock edge detection
   // ****************************************************************
   // The test clock is slow against mclk, so sampling it and acting on
   // its edges keeps all scan logic in one domain.
   logic                      tck_m_q;
   logic                      tck_s_q;
   logic                      tck_p_q;
   logic                      tms_m_q;
   logic                      tms_s_q;
   logic                      tdi_m_q;
   logic                      tdi_s_q;
   logic                      pll_m_q;
   logic                      pll_s_q;

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         {tck_m_q, tck_s_q, tck_p_q} <= 3'h0;
         {tms_m_q, tms_s_q} <= 2'h3;
         {tdi_m_q, tdi_s_q} <= 2'h0;
         {pll_m_q, pll_s_q} <= 2'h0;
      end else begin
         {tck_m_q, tck_s_q, tck_p_q} <= {lnk.tck, tck_m_q, tck_s_q};
         {tms_m_q, tms_s_q} <= {lnk.tms, tms_m_q};
         {tdi_m_q, tdi_s_q} <= {lnk.tdi, tdi_m_q};
         {pll_m_q, pll_s_q} <= {lnk.pll_disable_input, pll_m_q};
      end
   end

   wire tck_rise = tck_s_q & ~tck_p_q;
   wire tck_fall = ~tck_s_q & tck_p_q;

   // ****************************************************************
   // Controller state
   // ****************************************************************
   sbst_pkg::sbst_tap_t       st_q;
   sbst_pkg::sbst_tap_t       st_d;

   assign st_d = tck_rise ? next_st(st_q, tms_s_q) : st_q;

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         st_q <= sbst_pkg::sbst_tlr;
      end else begin
         st_q <= st_d;
      end
   end

   wire in_tlr    = st_q == sbst_pkg::sbst_tlr;
   wire in_cap_ir = st_q == sbst_pkg::sbst_cap_ir;
   wire in_shf_ir = st_q == sbst_pkg::sbst_shf_ir;
   wire in_upd_ir = st_q == sbst_pkg::sbst_upd_ir;
   wire in_cap_dr = st_q == sbst_pkg::sbst_cap_dr;
   wire in_shf_dr = st_q == sbst_pkg::sbst_shf_dr;
   wire in_upd_dr = st_q == sbst_pkg::sbst_upd_dr;

   // ****************************************************************
   // Instruction decode
   // ****************************************************************
   logic [`SBST_IR_W-1:0]     ir_sh_q;
   logic [`SBST_IR_W-1:0]     ir_sh_d;
   logic [`SBST_IR_W-1:0]     ir_q;
   logic [`SBST_IR_W-1:0]     ir_d;

   wire ins_ext  = ir_q == sbst_pkg::sbst_ins_extest;
   wire ins_idc  = ir_q == sbst_pkg::sbst_ins_idcode;
   wire ins_smpz = ir_q == sbst_pkg::sbst_ins_samplez;
   wire ins_smpl = ir_q == sbst_pkg::sbst_ins_sample;
   // Bypass code and the reserved codes all fall back to the bypass bit.
   wire sel_bsr  = ins_ext | ins_smpz | ins_smpl;
   wire sel_byp  = ~ins_idc & ~sel_bsr;

   // ****************************************************************
   // Scan chains
   // ****************************************************************
   logic [`SBST_ID_W-1:0]     id_sh_q;
   logic [`SBST_ID_W-1:0]     id_sh_d;
   logic [`SBST_BSR_W-1:0]    bsr_sh_q;
   logic [`SBST_BSR_W-1:0]    bsr_sh_d;
   logic [`SBST_BSR_W-1:0]    bsr_upd_q;
   logic [`SBST_BSR_W-1:0]    bsr_upd_d;
   logic                      byp_q;
   logic                      byp_d;
   logic [`SBST_ID_W-1:0]     id_val;

   assign id_val[`SBST_ID_VER_MSB:`SBST_ID_VER_LSB]     = ID_VER;
   assign id_val[`SBST_ID_PART_MSB:`SBST_ID_PART_LSB]   = ID_PART;
   assign id_val[`SBST_ID_MAKER_MSB:`SBST_ID_MAKER_LSB] = ID_MAKER;
   assign id_val[0]                                     = `SBST_ID_PRESENT;

   wire cap_dr = tck_rise & in_cap_dr;
   wire shf_dr = tck_rise & in_shf_dr;

   assign ir_sh_d = (tck_rise & in_cap_ir) ? `SBST_IR_CAPT :
                    (tck_rise & in_shf_ir) ? {tdi_s_q, ir_sh_q[`SBST_IR_W-1:1]} :
                    ir_sh_q;

   assign id_sh_d = (cap_dr & ins_idc) ? id_val :
                    (shf_dr & ins_idc) ? {tdi_s_q, id_sh_q[`SBST_ID_W-1:1]} :
                    id_sh_q;

   // The internal cell captures its own latched value.
   assign bsr_sh_d = (cap_dr & sel_bsr) ? {bsr_upd_q[`SBST_BSR_OE_BIT], ring_in} :
                     (shf_dr & sel_bsr) ? {tdi_s_q, bsr_sh_q[`SBST_BSR_W-1:1]} :
                     bsr_sh_q;

   assign byp_d = (cap_dr & sel_byp) ? 1'h0 :
                  (shf_dr & sel_byp) ? tdi_s_q :
                  byp_q;

   // Updates act on the falling test clock edge, as the standard asks.
   assign ir_d = in_tlr ? sbst_pkg::sbst_ins_idcode :
                 (tck_fall & in_upd_ir) ? ir_sh_q :
                 ir_q;

   assign bsr_upd_d = in_tlr ? {`SBST_OE_CELL_RST, bsr_upd_q[`SBST_BSR_W-2:0]} :
                      (tck_fall & in_upd_dr & sel_bsr) ? bsr_sh_q :
                      bsr_upd_q;

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         ir_sh_q   <= `SBST_IR_CAPT;
         ir_q      <= sbst_pkg::sbst_ins_idcode;
         id_sh_q   <= '0;
         bsr_sh_q  <= '0;
         bsr_upd_q <= '0;
         byp_q     <= 1'h0;
      end else begin
         ir_sh_q   <= ir_sh_d;
         ir_q      <= ir_d;
         id_sh_q   <= id_sh_d;
         bsr_sh_q  <= bsr_sh_d;
         bsr_upd_q <= bsr_upd_d;
         byp_q     <= byp_d;
      end
   end

   // ****************************************************************
   // Serial output
   // ****************************************************************
   wire tdo_bit = in_shf_ir ? ir_sh_q[0] :
                  ins_idc   ? id_sh_q[0] :
                  sel_bsr   ? bsr_sh_q[0] :
                  byp_q;
   wire shifting = in_shf_ir | in_shf_dr;

   logic                      tdo_q;
   logic                      tdo_oe_b_q;

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         tdo_q      <= 1'h0;
         tdo_oe_b_q <= 1'h1;
      end else if (tck_fall) begin
         tdo_q      <= tdo_bit;
         tdo_oe_b_q <= ~shifting;
      end
   end

   assign lnk.tdo      = tdo_q;
   assign lnk.tdo_oe_b = tdo_oe_b_q;

   // ****************************************************************
   // Memory-side controls
   // ****************************************************************
   // The forcing follows ir_q, which only moves at update or reset.
   wire q_hiz_d = ins_smpz | (ins_ext & ~bsr_upd_q[`SBST_BSR_OE_BIT]);

   logic                      q_hiz_q;
   logic                      extest_q;

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         q_hiz_q  <= 1'h0;
         extest_q <= 1'h0;
      end else begin
         q_hiz_q  <= q_hiz_d;
         extest_q <= ins_ext;
      end
   end

   assign q_hiz     = q_hiz_q;
   assign extest_on = extest_q;
   assign bsr_drive = bsr_upd_q[`SBST_BSR_W-2:0];

   // ****************************************************************
   // PLL lock tracking
   // ****************************************************************
   // The lock timer counts mclk, the PLL reference; the count is sized
   // for 125 MHz, which sits above the lowest usable rate.
   localparam logic [11:0] LOCK_CYC = 12'(`SBST_PLL_WAIT_CYC);
   logic [11:0]               lock_cnt_q;
   logic                      locked_q;

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         lock_cnt_q <= 12'h000;
         locked_q   <= 1'h0;
      end else if (!pll_s_q) begin
         lock_cnt_q <= 12'h000;
         locked_q   <= 1'h0;
      end else if (lock_cnt_q != LOCK_CYC) begin
         lock_cnt_q <= lock_cnt_q + 12'h001;
      end else begin
         locked_q   <= 1'h1;
      end
   end

   assign pll_locked = locked_q;
endmodule : sbst_dev
`default_nettype wire

// ---- sbst_host.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "sbst_map.svh"
// ****************************************************************
// Command FIFO
// ****************************************************************
module sbst_fifo #(
   parameter int W     = 2,
   parameter int DEPTH = 16
) (
   input  wire logic         mclk,
   input  wire logic         rst_b,
   input  wire logic         in_valid,
   output logic              in_ready,
   input  wire logic [W-1:0] in_data,
   output logic              out_valid,
   input  wire logic         out_ready,
   output logic [W-1:0]      out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [W-1:0]  mem [DEPTH];
   logic [AW-1:0] wr_q;
   logic [AW-1:0] rd_q;
   logic [AW:0]   cnt_q;
   logic [AW:0]   cnt_d;
   logic          in_ready_q;
   logic          out_valid_q;

   wire push = in_valid & in_ready_q;
   wire pop  = out_valid_q & out_ready;
   assign cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);

   always_ff @(posedge mclk) begin
      if (push) begin
         mem[wr_q] <= in_data;
      end
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         wr_q        <= '0;
         rd_q        <= '0;
         cnt_q       <= '0;
         in_ready_q  <= 1'h0;
         out_valid_q <= 1'h0;
      end else begin
         wr_q        <= wr_q + AW'(push);
         rd_q        <= rd_q + AW'(pop);
         cnt_q       <= cnt_d;
         in_ready_q  <= cnt_d != (AW+1)'(DEPTH);
         out_valid_q <= cnt_d != '0;
      end
   end

   assign in_ready  = in_ready_q;
   assign out_valid = out_valid_q;
   assign out_data  = mem[rd_q];
endmodule : sbst_fifo

// ****************************************************************
// Board test controller end
// ****************************************************************
module sbst_host #(
   parameter int PLL_WAIT = `SBST_PLL_WAIT_CYC,
   parameter int DEPTH    = 16
) (
   input  wire logic mclk,
   input  wire logic rst_b,
   sbst_if.host      lnk,
   input  wire logic cmd_valid,
   output logic      cmd_ready,
   input  wire logic cmd_tms,
   input  wire logic cmd_tdi,
   output logic      rsp_valid,
   output logic      rsp_tdo,
   output logic      pll_ready
);
   localparam logic [3:0]  HALF = 4'(`SBST_TCK_HALF_CYC);
   localparam logic [11:0] WAIT = 12'(PLL_WAIT);

   logic       f_valid;
   logic       f_pop;
   logic [1:0] f_data;

   sbst_fifo #(.W(2), .DEPTH(DEPTH)) u_fifo (
      .mclk      (mclk),
      .rst_b     (rst_b),
      .in_valid  (cmd_valid),
      .in_ready  (cmd_ready),
      .in_data   ({cmd_tms, cmd_tdi}),
      .out_valid (f_valid),
      .out_ready (f_pop),
      .out_data  (f_data)
   );

   sbst_pkg::sbst_eng_t eng_q;
   logic [11:0]         wait_q;
   logic [3:0]          half_q;
   logic [2:0]          rst_left_q;
   logic                pll_dis_q;
   logic                pll_rdy_q;
   logic                tck_q;
   logic                tms_q;
   logic                tdi_q;
   logic                want_q;
   logic                rsp_v_q;
   logic                rsp_q;
   logic                tdo_m_q;
   logic                tdo_s_q;

   wire idle     = eng_q == sbst_pkg::sbst_h_idle;
   wire rst_bit  = idle & (rst_left_q != 3'h0);
   assign f_pop  = idle & ~rst_bit & f_valid;
   wire half_end = half_q == HALF - 4'h1;

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         {tdo_m_q, tdo_s_q} <= 2'h0;
         pll_dis_q          <= 1'h0;
         pll_rdy_q          <= 1'h0;
         wait_q             <= 12'h000;
      end else begin
         {tdo_m_q, tdo_s_q} <= {lnk.tdo, tdo_m_q};
         pll_dis_q          <= 1'h1;
         if (wait_q != WAIT) begin
            wait_q <= wait_q + 12'h001;
         end else begin
            pll_rdy_q <= 1'h1;
         end
      end
   end

   // Five clocks with mode select high reach test-logic-reset from any
   // state, so the device starts from a known place.
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         eng_q      <= sbst_pkg::sbst_h_pll;
         half_q     <= 4'h0;
         rst_left_q <= 3'(`SBST_RST_TMS_CLKS);
         tck_q      <= 1'h0;
         tms_q      <= 1'h1;
         tdi_q      <= 1'h0;
         want_q     <= 1'h0;
         rsp_v_q    <= 1'h0;
         rsp_q      <= 1'h0;
      end else begin
         rsp_v_q <= 1'h0;
         case (eng_q)
            sbst_pkg::sbst_h_pll: begin
               if (pll_rdy_q) begin
                  eng_q <= sbst_pkg::sbst_h_idle;
               end
            end
            sbst_pkg::sbst_h_idle: begin
               half_q <= 4'h0;
               if (rst_bit) begin
                  {tms_q, tdi_q, want_q} <= 3'h4;
                  rst_left_q <= rst_left_q - 3'h1;
                  eng_q      <= sbst_pkg::sbst_h_low;
               end else if (f_valid) begin
                  {tms_q, tdi_q} <= f_data;
                  want_q <= 1'h1;
                  eng_q  <= sbst_pkg::sbst_h_low;
               end
            end
            sbst_pkg::sbst_h_low: begin
               half_q <= half_q + 4'h1;
               if (half_end) begin
                  half_q  <= 4'h0;
                  tck_q   <= 1'h1;
                  rsp_q   <= tdo_s_q;
                  rsp_v_q <= want_q;
                  eng_q   <= sbst_pkg::sbst_h_high;
               end
            end
            sbst_pkg::sbst_h_high: begin
               half_q <= half_q + 4'h1;
               if (half_end) begin
                  tck_q <= 1'h0;
                  eng_q <= sbst_pkg::sbst_h_idle;
               end
            end
            default: eng_q <= sbst_pkg::sbst_h_pll;
         endcase
      end
   end

   assign lnk.tck               = tck_q;
   assign lnk.tms               = tms_q;
   assign lnk.tdi               = tdi_q;
   assign lnk.pll_disable_input = pll_dis_q;
   assign rsp_valid             = rsp_v_q;
   assign rsp_tdo               = rsp_q;
   assign pll_ready             = pll_rdy_q;
endmodule : sbst_host
`default_nettype wire

// ---- sbst_if.sv ----
`timescale 1ns/100ps
`default_nettype none
interface sbst_if;
   logic tck;
   logic tms;
   logic tdi;
   logic tdo;
   logic tdo_oe_b;
   logic pll_disable_input;
   modport dev (
      input  tck,
      input  tms,
      input  tdi,
      input  pll_disable_input,
      output tdo,
      output tdo_oe_b
   );
   modport host (
      output tck,
      output tms,
      output tdi,
      output pll_disable_input,
      input  tdo,
      input  tdo_oe_b
   );
endinterface : sbst_if
`default_nettype wire

// ---- sbst_map.svh ----
`ifndef SBST_MAP_SVH
`define SBST_MAP_SVH
// ****************************************************************
// Scan register sizes and identification field layout
// ****************************************************************
`define SBST_IR_W          3
`define SBST_ID_W          32
`define SBST_BSR_W         109
`define SBST_BSR_OE_BIT    108
`define SBST_ID_VER_MSB    31
`define SBST_ID_VER_LSB    29
`define SBST_ID_PART_MSB   28
`define SBST_ID_PART_LSB   12
`define SBST_ID_MAKER_MSB  11
`define SBST_ID_MAKER_LSB  1
`define SBST_ID_PRESENT    1'h1
// ****************************************************************
// Reset and capture values
// ****************************************************************
`define SBST_IR_CAPT       3'h1
`define SBST_OE_CELL_RST   1'h0
// ****************************************************************
// Timing
// ****************************************************************
`define SBST_MCLK_NS       8
`define SBST_PLL_WAIT_NS   20000
`define SBST_PLL_WAIT_CYC  ((`SBST_PLL_WAIT_NS + `SBST_MCLK_NS - 1) / `SBST_MCLK_NS)
`define SBST_PLL_MIN_MHZ   120
`define SBST_TCK_HALF_NS   80
`define SBST_TCK_HALF_CYC  (`SBST_TCK_HALF_NS / `SBST_MCLK_NS)
`define SBST_RST_TMS_CLKS  5
`endif

// ---- sbst_pkg.sv ----
`default_nettype none
package sbst_pkg;
   // ****************************************************************
   // Instruction codes
   // ****************************************************************
   typedef enum logic [2:0] {
      sbst_ins_extest  = 3'h0,
      sbst_ins_idcode  = 3'h1,
      sbst_ins_samplez = 3'h2,
      sbst_ins_sample  = 3'h4,
      sbst_ins_bypass  = 3'h7
   } sbst_ins_t;
   // ****************************************************************
   // Test access controller states
   // ****************************************************************
   typedef enum logic [3:0] {
      sbst_tlr    = 4'h0,
      sbst_rti    = 4'h1,
      sbst_sel_dr = 4'h3,
      sbst_cap_dr = 4'h2,
      sbst_shf_dr = 4'h6,
      sbst_ex1_dr = 4'h7,
      sbst_pau_dr = 4'h5,
      sbst_ex2_dr = 4'h4,
      sbst_upd_dr = 4'hc,
      sbst_sel_ir = 4'hd,
      sbst_cap_ir = 4'hf,
      sbst_shf_ir = 4'he,
      sbst_ex1_ir = 4'ha,
      sbst_pau_ir = 4'hb,
      sbst_ex2_ir = 4'h9,
      sbst_upd_ir = 4'h8
   } sbst_tap_t;
   // ****************************************************************
   // Controller engine states
   // ****************************************************************
   typedef enum logic [2:0] {
      sbst_h_pll  = 3'h0,
      sbst_h_idle = 3'h1,
      sbst_h_low  = 3'h3,
      sbst_h_high = 3'h2
   } sbst_eng_t;
endpackage : sbst_pkg
`default_nettype wire

// ---- sbst_tap_assertions.sv ----
`timescale 1ns/100ps
`default_nettype none
module sbst_tap_assertions (
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic tck,
   input wire logic tms,
   input wire logic tdi,
   input wire logic tdo,
   input wire logic tdo_oe_b,
   input wire logic pll_disable_input
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_b);
   // ****************************************************************
   // Link timing
   // ****************************************************************
   tdo_on_fall_a: assert property ($changed(tdo) |-> !tck && !$past(tck))
      else $error("tdo moved with tck high");
   oe_on_fall_a: assert property ($changed(tdo_oe_b) |-> !tck && !$past(tck))
      else $error("tdo enable moved with tck high");
   tck_high_len_a: assert property ($rose(tck) |=> tck [*8])
      else $error("tck high too short");
   tck_low_len_a: assert property ($fell(tck) |=> !tck [*8])
      else $error("tck low too short");
   tms_hold_a: assert property (tck && $past(tck) |-> $stable(tms))
      else $error("tms moved with tck high");
   tdi_hold_a: assert property (tck && $past(tck) |-> $stable(tdi))
      else $error("tdi moved with tck high");
   // ****************************************************************
   // PLL enable
   // ****************************************************************
   pll_stays_on_a: assert property (!$fell(pll_disable_input))
      else $error("pll enable dropped");
   no_tck_early_a: assert property (!pll_disable_input |-> !tck)
      else $error("tck ran before pll enable");
endmodule : sbst_tap_assertions
`default_nettype wire

// ---- tb_sram_boundary_scan_tap.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "sbst_map.svh"
module tb_sram_boundary_scan_tap;
   logic                     mclk, rst_b, cmd_valid, cmd_tms, cmd_tdi;
   logic                     cmd_ready, rsp_valid, rsp_tdo, pll_ready;
   logic [`SBST_BSR_W-2:0]   bsr_drive;
   logic                     extest_on, q_hiz, pll_locked, saw_full;
   logic [`SBST_BSR_W-2:0]   ring_in = {27{4'ha}};
   logic [108:0]             r;
   logic [108:0]             pat = {1'h1, {27{4'h3}}};
   logic                     rq[$];
   int                       n_fail = 0, cmp_count = 0, cyc = 0;
   // The identification fields are arbitrary values, set apart from the defaults.
   localparam logic [31:0]   ID_EXP = {3'h2, 17'h1_3579, 11'h2a6, 1'h1};
   sbst_if lnk_if ();
   sbst_dev #(.ID_VER(ID_EXP[31:29]), .ID_PART(ID_EXP[28:12]), .ID_MAKER(ID_EXP[11:1]))
      sbst_dev_i (.mclk(mclk), .rst_b(rst_b), .lnk(lnk_if), .ring_in(ring_in),
      .bsr_drive(bsr_drive), .extest_on(extest_on), .q_hiz(q_hiz), .pll_locked(pll_locked));
   sbst_host #(.PLL_WAIT(50)) sbst_host_i (.mclk(mclk), .rst_b(rst_b), .lnk(lnk_if),
      .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_tms(cmd_tms), .cmd_tdi(cmd_tdi),
      .rsp_valid(rsp_valid), .rsp_tdo(rsp_tdo), .pll_ready(pll_ready));
   sbst_tap_assertions sbst_tap_assertions_i (.mclk(mclk), .rst_b(rst_b), .tck(lnk_if.tck),
      .tms(lnk_if.tms), .tdi(lnk_if.tdi), .tdo(lnk_if.tdo), .tdo_oe_b(lnk_if.tdo_oe_b),
      .pll_disable_input(lnk_if.pll_disable_input));
   initial begin
      mclk = 0;
      forever #4 mclk = ~mclk;
   end
   // ****************************************************************
   // Bus tasks
   // ****************************************************************
   task finish_test;
      if (n_fail == 0 && cmp_count > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : finish_test
   task chk(input logic [108:0] got, input logic [108:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_fail++;
         $display("CHECK FAILED %0t got %h want %h", $time, got, exp);
      end
   endtask : chk
   task push(input logic m, input logic d);
      @(posedge mclk);
      cmd_valid <= 1'h1;
      cmd_tms   <= m;
      cmd_tdi   <= d;
      do @(posedge mclk); while (cmd_ready !== 1'h1);
      cmd_valid <= 1'h0;
   endtask : push
   // Starts and ends in run-test-idle; bit k of a scan is seen at response p+k.
   task scan(input logic ir, input int n, input logic [108:0] din, output logic [108:0] dout);
      int p;
      p = ir ? 4 : 3;
      rq.delete();
      push(1'h1, 1'h0);
      if (ir) push(1'h1, 1'h0);
      push(1'h0, 1'h0);
      push(1'h0, 1'h0);
      for (int i = 0; i < n; i++) push(i == n - 1, din[i]);
      push(1'h1, 1'h0);
      push(1'h0, 1'h0);
      wait (rq.size() == p + n + 2);
      dout = '0;
      for (int i = 0; i < n; i++) dout[i] = rq[p + i];
   endtask : scan
   always @(posedge mclk) begin
      cyc++;
      if (rsp_valid === 1'h1) rq.push_back(rsp_tdo);
      if (pll_ready === 1'h1 && cmd_ready === 1'h0) saw_full = 1'h1;
      if (cyc == 40000) begin
         n_fail++;
         finish_test();
      end
   end
   // ****************************************************************
   // Tests
   // ****************************************************************
   initial begin
      rst_b = 0; cmd_valid = 0; cmd_tms = 0; cmd_tdi = 0; saw_full = 0;
      repeat (8) @(posedge mclk);
      rst_b <= 1'h1;
      wait (pll_ready === 1'h1);
      // The host runs its own reset clocks first, so let them drain.
      repeat (200) @(posedge mclk);
      push(1'h0, 1'h0);
      repeat (40) @(posedge mclk);
      scan(0, 32, 0, r);
      chk(r, ID_EXP);
      scan(1, 3, 3'h7, r);
      chk(r, 3'h1);
      scan(0, 3, 3'h5, r);
      chk(r, 3'h2);
      scan(1, 3, 3'h4, r);
      scan(0, 109, pat, r);
      chk(r, {1'h0, ring_in});
      chk(bsr_drive, pat[107:0]);
      scan(0, 109, pat, r);
      chk(r[108], 1'h1);
      scan(1, 3, 3'h2, r);
      chk(q_hiz, 1'h1);
      scan(1, 3, 3'h0, r);
      chk({extest_on, q_hiz}, 2'h2);
      scan(0, 109, 0, r);
      chk(q_hiz, 1'h1);
      scan(1, 3, 3'h1, r);
      chk({extest_on, q_hiz}, 2'h0);
      // Latch cell 108 high, then pass through test-logic-reset, which must clear it.
      scan(1, 3, 3'h4, r);
      scan(0, 109, pat, r);
      rq.delete();
      repeat (5) push(1'h1, 1'h0);
      push(1'h0, 1'h0);
      wait (rq.size() == 6);
      chk({extest_on, q_hiz}, 2'h0);
      scan(1, 3, 3'h0, r);
      chk({extest_on, q_hiz}, 2'h3);
      chk({pll_locked, saw_full}, 2'h3);
      finish_test();
   end
endmodule : tb_sram_boundary_scan_tap
`default_nettype wire
